//--- hw/pee_map.svh
`ifndef PEE_MAP_SVH
`define PEE_MAP_SVH

// clock
`define PEE_CLK_NS 10

// command codes on cmd_op_in
`define PEE_OP_READ 2'h0
`define PEE_OP_WRITE 2'h1
`define PEE_OP_LOCK_ON 2'h2
`define PEE_OP_LOCK_OFF 2'h3

// array geometry
`define PEE_ADDR_W 13
`define PEE_DATA_W 8
`define PEE_PAGE_LSB 5
`define PEE_PAGE_BYTES 32
`define PEE_POLL_BIT 7
`define PEE_TOGGLE_BIT 6

// sequence lengths
`define PEE_ENA_LEN 3
`define PEE_DIS_LEN 6

// times as printed
`define PEE_WRITE_PULSE_NS 110
`define PEE_READ_ACCESS_NS 150
`define PEE_BYTE_LOAD_WINDOW_US 100
`define PEE_WRITE_CYCLE_MS 5
`define PEE_POWERUP_LOCKOUT_MS 10

// derived cycle counts (least times round up)
`define PEE_WRITE_PULSE_CYC ((`PEE_WRITE_PULSE_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_READ_ACCESS_CYC ((`PEE_READ_ACCESS_NS + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_BYTE_LOAD_WINDOW_CYC ((`PEE_BYTE_LOAD_WINDOW_US * 1000 + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_WRITE_CYCLE_CYC ((`PEE_WRITE_CYCLE_MS * 1000000 + `PEE_CLK_NS - 1) / `PEE_CLK_NS)
`define PEE_POWERUP_LOCKOUT_CYC ((`PEE_POWERUP_LOCKOUT_MS * 1000000 + `PEE_CLK_NS - 1) / `PEE_CLK_NS)

// cycles kept in hand before the load window closes
`define PEE_GAP_GUARD_CYC 16

// timer width
`define PEE_TIMER_W 20

`endif

//--- hw/pee_pkg.sv
`include "pee_map.svh"

package pee_pkg;
    typedef enum logic [3:0] {
        PEE_ST_LOCKOUT,
        PEE_ST_IDLE,
        PEE_ST_W_SET,
        PEE_ST_W_PULSE,
        PEE_ST_W_HOLD,
        PEE_ST_GAP,
        PEE_ST_R_ACC,
        PEE_ST_R_REL
    } pee_state_t;
endpackage

//--- hw/pee_timer.sv
`timescale 1ns/1ps
`default_nettype none

module pee_timer #(
    parameter int unsigned W = 20,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // control
    input wire logic load_in,
    input wire logic [W-1:0] value_in,
    // status
    output logic [W-1:0] count_out,
    output logic expired_out
);
    logic [W-1:0] count;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            count <= RST_VAL;
        end else if (load_in) begin
            count <= value_in;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign count_out = count;
    assign expired_out = (count == '0);
endmodule

`default_nettype wire

//--- hw/pee_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "pee_map.svh"

module pee_host #(
    parameter int unsigned LOCKOUT_CYC = `PEE_POWERUP_LOCKOUT_CYC,
    parameter int unsigned WINDOW_CYC = `PEE_BYTE_LOAD_WINDOW_CYC,
    parameter int unsigned WRITE_CYC = `PEE_WRITE_CYCLE_CYC,
    parameter logic [`PEE_ENA_LEN-1:0][`PEE_ADDR_W-1:0] ENA_ADDR = {13'h0003, 13'h0002, 13'h0001},
    parameter logic [`PEE_ENA_LEN-1:0][`PEE_DATA_W-1:0] ENA_DATA = {8'h03, 8'h02, 8'h01},
    parameter logic [`PEE_DIS_LEN-1:0][`PEE_ADDR_W-1:0] DIS_ADDR =
        {13'h0006, 13'h0005, 13'h0004, 13'h0003, 13'h0002, 13'h0001},
    parameter logic [`PEE_DIS_LEN-1:0][`PEE_DATA_W-1:0] DIS_DATA =
        {8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01}
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // command port
    input wire logic cmd_valid_in,
    input wire logic [1:0] cmd_op_in,
    input wire logic [`PEE_ADDR_W-1:0] cmd_addr_in,
    input wire logic [`PEE_DATA_W-1:0] cmd_data_in,
    input wire logic cmd_last_in,
    input wire logic protect_in,
    output logic cmd_ready_out,
    // results
    output logic rd_valid_out,
    output logic [`PEE_DATA_W-1:0] rd_data_out,
    output logic wr_done_out,
    output logic wr_timeout_out,
    output logic busy_out,
    // memory pins
    output logic [`PEE_ADDR_W-1:0] mem_addr_out,
    output logic [`PEE_DATA_W-1:0] mem_dq_out,
    output logic mem_dq_oe_out,
    input wire logic [`PEE_DATA_W-1:0] mem_dq_in,
    output logic mem_cs_n_out,
    output logic mem_oe_n_out,
    output logic mem_we_n_out
);
    localparam int unsigned TW = `PEE_TIMER_W;

    pee_pkg::pee_state_t state, next_state;
    logic [1:0] op;
    logic [`PEE_ADDR_W-1:0] u_addr;
    logic [`PEE_DATA_W-1:0] u_data, sample;
    logic u_last, seq_on, seq_dis, user_pending, page_open, polling, poll_first, prev6;
    logic [2:0] seq_idx;
    logic [5:0] load_cnt;
    logic [`PEE_ADDR_W-1:0] cur_addr;
    logic [`PEE_DATA_W-1:0] cur_data;
    logic accept_idle, accept_gap, seq_more, poll_ok;
    logic s_load, l_load, s_exp, l_exp;
    logic [TW-1:0] s_val, s_cnt, l_val;

    // short timer: strobe pulse, read access, load window
    pee_timer #(.W(TW), .RST_VAL('0)) u_short (
        .clk_in(ref_clk_in),
        .srst_in(srst_in),
        .load_in(s_load),
        .value_in(s_val),
        .count_out(s_cnt),
        .expired_out(s_exp)
    );

    // long timer: power-up lockout, then write cycle timeout
    pee_timer #(.W(TW), .RST_VAL(TW'(LOCKOUT_CYC))) u_long (
        .clk_in(ref_clk_in),
        .srst_in(srst_in),
        .load_in(l_load),
        .value_in(l_val),
        .count_out(),
        .expired_out(l_exp)
    );

    assign seq_more = seq_on && (seq_idx != (seq_dis ? 3'(`PEE_DIS_LEN - 1) : 3'(`PEE_ENA_LEN - 1)));
    assign accept_idle = (state == pee_pkg::PEE_ST_IDLE) && cmd_valid_in && cmd_ready_out;
    // further loads only into the same page, before the guard, up to a full page
    assign accept_gap = (state == pee_pkg::PEE_ST_GAP) && cmd_valid_in && cmd_ready_out
        && page_open && (cmd_op_in == `PEE_OP_WRITE)
        && (cmd_addr_in[`PEE_ADDR_W-1:`PEE_PAGE_LSB] == u_addr[`PEE_ADDR_W-1:`PEE_PAGE_LSB]);
    assign poll_ok = !poll_first && (sample[`PEE_POLL_BIT] == u_data[`PEE_POLL_BIT])
        && (sample[`PEE_TOGGLE_BIT] == prev6);

    always_comb begin
        cur_addr = u_addr;
        cur_data = u_data;
        if (seq_on && (state != pee_pkg::PEE_ST_R_ACC)) begin
            cur_addr = seq_dis ? DIS_ADDR[seq_idx] : ENA_ADDR[seq_idx[1:0]];
            cur_data = seq_dis ? DIS_DATA[seq_idx] : ENA_DATA[seq_idx[1:0]];
        end
    end

    always_comb begin
        next_state = state;
        s_load = 1'b0;
        s_val = '0;
        l_load = 1'b0;
        l_val = '0;
        case (state)
            pee_pkg::PEE_ST_LOCKOUT: begin
                if (l_exp) begin
                    next_state = pee_pkg::PEE_ST_IDLE;
                end
            end
            pee_pkg::PEE_ST_IDLE: begin
                if (accept_idle) begin
                    if (cmd_op_in == `PEE_OP_READ) begin
                        next_state = pee_pkg::PEE_ST_R_ACC;
                        s_load = 1'b1;
                        s_val = TW'(`PEE_READ_ACCESS_CYC);
                    end else begin
                        next_state = pee_pkg::PEE_ST_W_SET;
                    end
                end
            end
            pee_pkg::PEE_ST_W_SET: begin
                next_state = pee_pkg::PEE_ST_W_PULSE;
                s_load = 1'b1;
                s_val = TW'(`PEE_WRITE_PULSE_CYC - 1);
            end
            pee_pkg::PEE_ST_W_PULSE: begin
                if (s_exp) begin
                    next_state = pee_pkg::PEE_ST_W_HOLD;
                end
            end
            pee_pkg::PEE_ST_W_HOLD: begin
                // window restarts at every rising strobe
                s_load = 1'b1;
                s_val = TW'(WINDOW_CYC);
                if (seq_more || (seq_on && user_pending)) begin
                    next_state = pee_pkg::PEE_ST_W_SET;
                end else begin
                    next_state = pee_pkg::PEE_ST_GAP;
                end
            end
            pee_pkg::PEE_ST_GAP: begin
                if (accept_gap) begin
                    next_state = pee_pkg::PEE_ST_W_SET;
                end else if (s_exp) begin
                    // strobe held high a whole window: program cycle now runs
                    if (op == `PEE_OP_WRITE) begin
                        next_state = pee_pkg::PEE_ST_R_ACC;
                        s_load = 1'b1;
                        s_val = TW'(`PEE_READ_ACCESS_CYC);
                        l_load = 1'b1;
                        l_val = TW'(WRITE_CYC);
                    end else begin
                        next_state = pee_pkg::PEE_ST_IDLE;
                    end
                end
            end
            pee_pkg::PEE_ST_R_ACC: begin
                if (s_exp) begin
                    next_state = pee_pkg::PEE_ST_R_REL;
                end
            end
            pee_pkg::PEE_ST_R_REL: begin
                if (polling && !poll_ok && !l_exp) begin
                    next_state = pee_pkg::PEE_ST_R_ACC;
                    s_load = 1'b1;
                    s_val = TW'(`PEE_READ_ACCESS_CYC);
                end else begin
                    next_state = pee_pkg::PEE_ST_IDLE;
                end
            end
            default: begin
                next_state = pee_pkg::PEE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            state <= pee_pkg::PEE_ST_LOCKOUT;
        end else begin
            state <= next_state;
        end
    end

    // command capture and lock sequencing
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            op <= `PEE_OP_READ;
            u_addr <= '0;
            u_data <= '0;
            u_last <= 1'b1;
            seq_on <= 1'b0;
            seq_dis <= 1'b0;
            seq_idx <= '0;
            user_pending <= 1'b0;
            load_cnt <= '0;
        end else if (accept_idle) begin
            op <= cmd_op_in;
            u_addr <= cmd_addr_in;
            u_data <= cmd_data_in;
            u_last <= cmd_last_in;
            seq_idx <= '0;
            load_cnt <= '0;
            seq_dis <= (cmd_op_in == `PEE_OP_LOCK_OFF);
            seq_on <= (cmd_op_in == `PEE_OP_LOCK_ON) || (cmd_op_in == `PEE_OP_LOCK_OFF)
                || ((cmd_op_in == `PEE_OP_WRITE) && protect_in);
            user_pending <= (cmd_op_in == `PEE_OP_WRITE);
        end else if (accept_gap) begin
            u_addr <= cmd_addr_in;
            u_data <= cmd_data_in;
            u_last <= cmd_last_in;
        end else if (state == pee_pkg::PEE_ST_W_HOLD) begin
            if (seq_more) begin
                seq_idx <= seq_idx + 3'h1;
            end else if (seq_on) begin
                seq_on <= 1'b0;
            end else begin
                user_pending <= 1'b0;
                load_cnt <= load_cnt + 6'h01;
            end
        end
    end

    // page stays open until the last flag or a full page of loads
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            page_open <= 1'b0;
        end else if (state == pee_pkg::PEE_ST_W_HOLD) begin
            page_open <= (op == `PEE_OP_WRITE) && !u_last && (load_cnt != 6'(`PEE_PAGE_BYTES - 1));
        end
    end

    // read sampling and completion polling
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            sample <= '0;
            polling <= 1'b0;
            poll_first <= 1'b1;
            prev6 <= 1'b0;
        end else begin
            if (accept_idle) begin
                polling <= 1'b0;
            end else if ((state == pee_pkg::PEE_ST_GAP) && (next_state == pee_pkg::PEE_ST_R_ACC)) begin
                polling <= 1'b1;
                poll_first <= 1'b1;
            end
            if ((state == pee_pkg::PEE_ST_R_ACC) && s_exp) begin
                sample <= mem_dq_in;
            end
            if (state == pee_pkg::PEE_ST_R_REL) begin
                prev6 <= sample[`PEE_TOGGLE_BIT];
                poll_first <= 1'b0;
            end
        end
    end

    // result pulses and handshake
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            cmd_ready_out <= 1'b0;
            rd_valid_out <= 1'b0;
            rd_data_out <= '0;
            wr_done_out <= 1'b0;
            wr_timeout_out <= 1'b0;
            busy_out <= 1'b1;
        end else begin
            // guard keeps the next falling strobe inside the window
            cmd_ready_out <= ((next_state == pee_pkg::PEE_ST_IDLE) && !accept_idle)
                || ((next_state == pee_pkg::PEE_ST_GAP) && page_open && !accept_gap
                    && (state == pee_pkg::PEE_ST_GAP) && (s_cnt > TW'(`PEE_GAP_GUARD_CYC)));
            rd_valid_out <= (state == pee_pkg::PEE_ST_R_REL) && !polling;
            rd_data_out <= sample;
            wr_done_out <= ((state == pee_pkg::PEE_ST_R_REL) && polling && (poll_ok || l_exp))
                || ((state == pee_pkg::PEE_ST_GAP) && s_exp && !accept_gap && (op != `PEE_OP_WRITE));
            wr_timeout_out <= (state == pee_pkg::PEE_ST_R_REL) && polling && !poll_ok && l_exp;
            busy_out <= (next_state != pee_pkg::PEE_ST_IDLE);
        end
    end

    // pin drive, one cycle behind the state
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            mem_addr_out <= '0;
            mem_dq_out <= '0;
            mem_dq_oe_out <= 1'b0;
            mem_cs_n_out <= 1'b1;
            mem_oe_n_out <= 1'b1;
            mem_we_n_out <= 1'b1;
        end else begin
            case (state)
                pee_pkg::PEE_ST_W_SET, pee_pkg::PEE_ST_W_PULSE, pee_pkg::PEE_ST_W_HOLD: begin
                    // address and data held steady across both strobe edges
                    mem_addr_out <= cur_addr;
                    mem_dq_out <= cur_data;
                    mem_dq_oe_out <= 1'b1;
                    mem_cs_n_out <= 1'b0;
                    mem_oe_n_out <= 1'b1;
                    mem_we_n_out <= (state != pee_pkg::PEE_ST_W_PULSE);
                end
                pee_pkg::PEE_ST_R_ACC: begin
                    mem_addr_out <= u_addr;
                    mem_dq_oe_out <= 1'b0;
                    mem_cs_n_out <= 1'b0;
                    mem_oe_n_out <= 1'b0;
                    mem_we_n_out <= 1'b1;
                end
                default: begin
                    // idle, gap, lockout and read release: select high inhibits writes
                    mem_dq_oe_out <= 1'b0;
                    mem_cs_n_out <= 1'b1;
                    mem_oe_n_out <= 1'b1;
                    mem_we_n_out <= 1'b1;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

//--- testbench/pee_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pee_map.svh"
module pee_host_monitor #(
    parameter int unsigned LOCKOUT_CYC = 200,
    parameter int unsigned WINDOW_CYC = 100
) (
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic srst_in,
    // command side
    input wire logic cmd_valid_in,
    input wire logic [1:0] cmd_op_in,
    input wire logic cmd_ready_out,
    input wire logic rd_valid_out,
    input wire logic wr_done_out,
    input wire logic wr_timeout_out,
    input wire logic busy_out,
    // memory pins
    input wire logic [`PEE_ADDR_W-1:0] mem_addr_out,
    input wire logic [`PEE_DATA_W-1:0] mem_dq_out,
    input wire logic mem_dq_oe_out,
    input wire logic mem_cs_n_out,
    input wire logic mem_oe_n_out,
    input wire logic mem_we_n_out
);
    int unsigned up_cnt;
    int unsigned hi_cnt;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    // both counters saturate so long runs cannot wrap
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) up_cnt <= 0;
        else if (up_cnt < LOCKOUT_CYC) up_cnt <= up_cnt + 1;
    end
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !mem_we_n_out) hi_cnt <= 0;
        else if (hi_cnt < WINDOW_CYC) hi_cnt <= hi_cnt + 1;
    end
    bus_turn_a: assert property (mem_dq_oe_out |-> mem_oe_n_out)
        else $error("host drives dq while device output is enabled");
    write_gate_a: assert property (!mem_we_n_out |-> mem_oe_n_out && !mem_cs_n_out)
        else $error("write strobe low without select or with output enabled");
    pulse_width_a: assert property ($fell(mem_we_n_out) |=> !mem_we_n_out [*8])
        else $error("write pulse too short");
    load_stable_a: assert property (!mem_we_n_out |=> mem_we_n_out || $stable(mem_addr_out) && $stable(mem_dq_out))
        else $error("address or data moved during write pulse");
    data_hold_a: assert property ($rose(mem_we_n_out) |-> !mem_cs_n_out && mem_dq_oe_out)
        else $error("data not held at strobe rise");
    lockout_a: assert property (cmd_ready_out |-> up_cnt >= LOCKOUT_CYC - 1)
        else $error("command accepted inside power-up lockout");
    window_a: assert property (wr_done_out |-> hi_cnt >= WINDOW_CYC - 1)
        else $error("write reported done before load window closed");
    timeout_a: assert property (wr_timeout_out |-> wr_done_out)
        else $error("timeout without done");
    read_ans_a: assert property (cmd_valid_in && cmd_ready_out && cmd_op_in == `PEE_OP_READ |=> !cmd_ready_out ##[1:40] rd_valid_out)
        else $error("read not answered in time");
    idle_pins_a: assert property (!busy_out |-> mem_cs_n_out && mem_we_n_out)
        else $error("strobes active while idle");
    read_c: cover property (rd_valid_out);
    done_c: cover property (wr_done_out && !wr_timeout_out);
    tmo_c: cover property (wr_timeout_out);
endmodule
`default_nettype wire

//--- testbench/pee_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module pee_dev_model #(
    parameter int unsigned PWR_CYC = 150,
    parameter int unsigned LOAD_WIN_CYC = 90,
    parameter int unsigned PROG_CYC = 150
) (
    // clock and fault control
    input wire logic clk_in,
    input wire logic slow_in,
    // memory pins
    input wire logic cs_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [12:0] addr_in,
    input wire logic [7:0] dq_in,
    output logic [7:0] dq_out
);
    logic [7:0] arr [8192];
    logic [12:0] ld_a [$];
    logic [7:0] ld_d [$];
    logic [12:0] a_lat = '0;
    logic [12:0] last_a = '0;
    logic wr_on = 1'b0;
    logic rd_on = 1'b0;
    logic tgl = 1'b0;
    logic lock = 1'b0;
    logic [7:0] lst = 8'h00;
    int unsigned pwr = 0;
    int unsigned win_cnt = 0;
    int unsigned prog = 0;
    wire logic rd_now = !cs_n_in && !oe_n_in && we_n_in;
    initial foreach (arr[i]) arr[i] = 8'hff;
    // released bus shows the inverse of the last value, never a stale copy
    assign dq_out = !rd_now ? ~lst :
        (prog != 0) ? {~arr[last_a][7], tgl, 6'h2a} : arr[addr_in];
    // sequence values mirror the host's default parameters
    function automatic logic seq(input int k);
        for (int j = 0; j < k; j++)
            if (ld_a[j] != 13'(j + 1) || ld_d[j] != 8'(j + 1)) return 1'b0;
        return 1'b1;
    endfunction
    task automatic commit();
        int n;
        int i;
        n = ld_a.size();
        i = 0;
        if (n == 6 && seq(6)) begin
            lock = 1'b0;
            i = n;
        end else if (n >= 3 && seq(3)) begin
            lock = 1'b1;
            i = 3;
        end else if (lock) begin
            i = n;
        end
        if (i < n) begin
            last_a = ld_a[n-1];
            prog = slow_in ? 4 * PROG_CYC : PROG_CYC;
        end
        while (i < n) begin
            arr[{ld_a[n-1][12:5], ld_a[i][4:0]}] = ld_d[i];
            i++;
        end
        ld_a.delete();
        ld_d.delete();
    endtask
    always @(posedge clk_in) begin
        logic wr_now;
        wr_now = !cs_n_in && !we_n_in && oe_n_in && pwr >= PWR_CYC;
        if (pwr < PWR_CYC) pwr++;
        if (prog != 0) prog--;
        if (rd_on && !rd_now) tgl = ~tgl;
        if (rd_now) lst = dq_out;
        rd_on = rd_now;
        if (wr_now && !wr_on) a_lat = addr_in;
        if (wr_on && !wr_now) begin
            ld_a.push_back(a_lat);
            ld_d.push_back(dq_in);
            win_cnt = 1;
        end else if (wr_now) begin
            win_cnt = 0;
        end else if (win_cnt != 0) begin
            win_cnt++;
            if (win_cnt > LOAD_WIN_CYC) begin
                win_cnt = 0;
                commit();
            end
        end
        wr_on = wr_now;
    end
endmodule
`default_nettype wire

//--- testbench/test_parallel_eeprom_write_control.sv
`timescale 1ns/1ps
`default_nettype none
`include "pee_map.svh"
module test_parallel_eeprom_write_control;
    logic ref_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic cmd_valid_in = 1'b0;
    logic [1:0] cmd_op_in = 2'h0;
    logic [12:0] cmd_addr_in = 13'h0000;
    logic [7:0] cmd_data_in = 8'h00;
    logic cmd_last_in = 1'b0;
    logic protect_in = 1'b0;
    logic slow = 1'b0;
    logic cmd_ready_out, rd_valid_out, wr_done_out, wr_timeout_out, busy_out;
    logic [12:0] mem_addr_out;
    logic [7:0] rd_data_out, mem_dq_out, dev_dq, mem_dq_in;
    logic mem_dq_oe_out, mem_cs_n_out, mem_oe_n_out, mem_we_n_out;
    int error_cnt = 0;
    int check_count = 0;
    assign mem_dq_in = mem_dq_oe_out ? mem_dq_out : dev_dq;
    pee_host #(.LOCKOUT_CYC(200), .WINDOW_CYC(100), .WRITE_CYC(400)) u_pee_host (
        .ref_clk_in, .srst_in, .cmd_valid_in, .cmd_op_in, .cmd_addr_in, .cmd_data_in,
        .cmd_last_in, .protect_in, .cmd_ready_out, .rd_valid_out, .rd_data_out, .wr_done_out,
        .wr_timeout_out, .busy_out, .mem_addr_out, .mem_dq_out, .mem_dq_oe_out, .mem_dq_in,
        .mem_cs_n_out, .mem_oe_n_out, .mem_we_n_out
    );
    pee_dev_model u_pee_dev_model (
        .clk_in(ref_clk_in), .slow_in(slow), .cs_n_in(mem_cs_n_out), .oe_n_in(mem_oe_n_out),
        .we_n_in(mem_we_n_out), .addr_in(mem_addr_out), .dq_in(mem_dq_out), .dq_out(dev_dq)
    );
    initial forever #5 ref_clk_in = ~ref_clk_in;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [1:0] op, input logic [12:0] a, input logic [7:0] d, input logic last);
        int n;
        n = 0;
        @(negedge ref_clk_in);
        cmd_valid_in = 1'b1;
        cmd_op_in = op;
        cmd_addr_in = a;
        cmd_data_in = d;
        cmd_last_in = last;
        while (cmd_ready_out !== 1'b1 && n < 50000) begin
            @(negedge ref_clk_in);
            n++;
        end
        @(negedge ref_clk_in);
        cmd_valid_in = 1'b0;
    endtask
    task automatic wait_done(output int n, output logic to);
        n = 0;
        while (wr_done_out !== 1'b1 && n < 50000) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk({7'h0, wr_done_out}, 8'h01);
        to = wr_timeout_out;
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic p, output int n, output logic to);
        protect_in = p;
        cmd(`PEE_OP_WRITE, a, d, 1'b1);
        wait_done(n, to);
    endtask
    task automatic rd(input logic [12:0] a, output logic [7:0] d);
        int n;
        n = 0;
        cmd(`PEE_OP_READ, a, 8'h00, 1'b0);
        while (rd_valid_out !== 1'b1 && n < 100) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk({7'h0, rd_valid_out}, 8'h01);
        d = rd_data_out;
    endtask
    task automatic t_lockout();
        int n;
        n = 0;
        chk({7'h0, busy_out}, 8'h01);
        while (cmd_ready_out !== 1'b1 && n < 1000) begin
            @(negedge ref_clk_in);
            n++;
        end
        chk({7'h0, cmd_ready_out && n >= 199}, 8'h01);
        $display("test lockout done");
    endtask
    task automatic t_byte();
        int n;
        logic to;
        logic [7:0] d;
        wr(13'h0123, 8'ha5, 1'b0, n, to);
        chk({7'h0, to}, 8'h00);
        // done only after window plus device program time
        chk({7'h0, n > 240}, 8'h01);
        rd(13'h0123, d);
        chk(d, 8'ha5);
        $display("test byte done");
    endtask
    task automatic t_page();
        int n;
        logic to;
        logic [7:0] d;
        protect_in = 1'b0;
        cmd(`PEE_OP_WRITE, 13'h00bf, 8'h11, 1'b0);
        cmd(`PEE_OP_WRITE, 13'h00a2, 8'h22, 1'b0);
        cmd(`PEE_OP_WRITE, 13'h00a7, 8'h33, 1'b1);
        wait_done(n, to);
        chk({7'h0, to}, 8'h00);
        rd(13'h00bf, d);
        chk(d, 8'h11);
        rd(13'h00a2, d);
        chk(d, 8'h22);
        rd(13'h00a7, d);
        chk(d, 8'h33);
        rd(13'h00a5, d);
        chk(d, 8'hff);
        $display("test page done");
    endtask
    task automatic t_lock();
        int n;
        logic to;
        logic [7:0] d;
        cmd(`PEE_OP_LOCK_ON, 13'h0000, 8'h00, 1'b0);
        wait_done(n, to);
        chk({7'h0, to}, 8'h00);
        // unprefixed write is dropped, so polling never completes
        wr(13'h0200, 8'h5a, 1'b0, n, to);
        chk({7'h0, to}, 8'h01);
        rd(13'h0200, d);
        chk(d, 8'hff);
        wr(13'h0200, 8'h5a, 1'b1, n, to);
        chk({7'h0, to}, 8'h00);
        rd(13'h0200, d);
        chk(d, 8'h5a);
        cmd(`PEE_OP_LOCK_OFF, 13'h0000, 8'h00, 1'b0);
        wait_done(n, to);
        chk({7'h0, to}, 8'h00);
        wr(13'h0201, 8'hc3, 1'b0, n, to);
        chk({7'h0, to}, 8'h00);
        rd(13'h0201, d);
        chk(d, 8'hc3);
        $display("test lock done");
    endtask
    task automatic t_slow();
        int n;
        logic to;
        logic [7:0] d;
        slow = 1'b1;
        wr(13'h0300, 8'h0f, 1'b0, n, to);
        chk({7'h0, to}, 8'h01);
        slow = 1'b0;
        // let the overlong device cycle finish before reading back
        repeat (400) @(negedge ref_clk_in);
        rd(13'h0300, d);
        chk(d, 8'h0f);
        $display("test slow done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge ref_clk_in);
        srst_in = 1'b0;
        t_lockout();
        t_byte();
        t_page();
        t_lock();
        t_slow();
        stop_test();
    end
    initial begin
        #200_000;
        error_cnt++;
        $display("FAIL %0t watchdog expired", $time);
        stop_test();
    end
endmodule
bind pee_host pee_host_monitor #(.LOCKOUT_CYC(LOCKOUT_CYC), .WINDOW_CYC(WINDOW_CYC)) u_pee_host_monitor (
    .ref_clk_in, .srst_in, .cmd_valid_in, .cmd_op_in, .cmd_ready_out, .rd_valid_out, .wr_done_out,
    .wr_timeout_out, .busy_out, .mem_addr_out, .mem_dq_out, .mem_dq_oe_out, .mem_cs_n_out,
    .mem_oe_n_out, .mem_we_n_out
);
`default_nettype wire
